// ---- shared/rdma_pkg.sv ----
// Shared constants and carrier types for the receive DMA read channel.
// Assumes a 32-bit APB register port and a byte-wide processor data bus.
package rdma_pkg;

    // ==========================================================
    // Register map
    localparam logic [11:0] RDMA_CFG_OFFSET = 12'h000;
    localparam logic [11:0] RDMA_STATUS_OFFSET = 12'h004;
    localparam logic [7:0] RDMA_CFG_RESET = 8'h00;

    // ==========================================================
    // Configuration field positions
    localparam int RDMA_CFG_RST_BIT = 7;
    localparam int RDMA_CFG_ENB_BIT = 6;
    localparam int RDMA_CFG_RDTYPE_BIT = 5;
    localparam int RDMA_CFG_CHAN_MSB = 2;
    localparam int RDMA_CFG_CHAN_LSB = 0;
    localparam logic [7:0] RDMA_CFG_WR_MASK = 8'hE7;

    // ==========================================================
    // Status field positions
    localparam int RDMA_STAT_MSGS_LSB = 0;
    localparam int RDMA_STAT_REQ_BIT = 8;
    localparam int RDMA_STAT_VALID_BIT = 9;
    localparam int RDMA_STAT_UNASSIGNED_BIT = 10;

    // ==========================================================
    // Sizes
    localparam int RDMA_NUM_CHANNELS = 4;
    localparam int RDMA_FIFO_DEPTH = 16;
    localparam int RDMA_DATA_W = 8;
    localparam int RDMA_MSGS_W = 5;

    // Synchronised pin positions
    localparam int RDMA_PIN_RD = 0;
    localparam int RDMA_PIN_WR = 1;
    localparam int RDMA_PIN_ACK = 2;

    // ==========================================================
    // One word of a received message, last marks its end
    typedef struct packed {
        logic last;
        logic [RDMA_DATA_W-1:0] data;
    } rdma_word_t;

    localparam int RDMA_WORD_W = $bits(rdma_word_t);

    // State of the channel core
    typedef struct packed {
        logic [7:0] cfg;
        logic rst_prev;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic req;
        logic [RDMA_MSGS_W-1:0] msgs;
        logic [RDMA_DATA_W-1:0] data;
        logic oe;
        logic [31:0] prdata;
    } rdma_state_t;

endpackage

// ---- logic/rdma_fifo.sv ----
// Word FIFO with valid/ready on both sides and a synchronous flush.
// Assumes one clock; flush wins over a push or pop in the same cycle.
`timescale 1ns/100ps
module rdma_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    input wire logic flush,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // Pointers carry one extra bit to tell full from empty
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } rdma_fifo_state_t;

    rdma_fifo_state_t st_q;
    rdma_fifo_state_t st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Full when pointers differ only in the wrap bit
    assign in_ready = !((st_q.wr[AW] != st_q.rd[AW]) && (st_q.wr[AW-1:0] == st_q.rd[AW-1:0]));
    assign out_valid = (st_q.wr != st_q.rd);
    assign out_data = mem[st_q.rd[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers
    always_comb begin
        st_d = st_q;
        if (flush) begin
            st_d = '0;
        end else begin
            if (push) begin
                st_d.wr = st_q.wr + 1'b1;
            end
            if (pop) begin
                st_d.rd = st_q.rd + 1'b1;
            end
        end
    end

    // Pointer registers
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Storage has no reset; only written words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st_q.wr[AW-1:0]] <= in_data;
        end
    end
endmodule

// ---- logic/rdma_core.sv ----
// Receive DMA read channel: moves whole messages from the selected line
// channel's receive buffer to an external DMA controller over the
// processor data bus, configured over APB.
// Assumes the bus pins are asynchronous and the channel streams are on core_clk.
//
// How it works
// - A 0-to-1 change of the soft reset bit flushes the channel.
// - Requests and intake happen only while the enable bit is set.
// - A request is raised only when a complete message is buffered.
// - Each read cycle begins with the request output driven low.
// - With read-type 0, each read strobe falling edge presents a new word.
// - With read-type 1, each write strobe falling edge presents a new word.
// - Read-type bit picks read strobe (0) or write strobe with direction (1).
// - Channel field bits 2:0 pick line channel; codes 1xx are reserved.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module rdma_core
    import rdma_pkg::*;
#(
    parameter int FIFO_DEPTH = RDMA_FIFO_DEPTH,
    parameter int NUM_CHANNELS = RDMA_NUM_CHANNELS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive buffer streams from the line channels
    input wire rdma_word_t [NUM_CHANNELS-1:0] ch_word,
    input wire logic [NUM_CHANNELS-1:0] ch_valid,
    output logic [NUM_CHANNELS-1:0] ch_ready,
    // DMA handshake pins
    output logic rx_transfer_request_n,
    input wire logic rx_transfer_acknowledge_n,
    // Processor bus strobes
    input wire logic rd_n,
    input wire logic wr_n,
    // Processor data bus, driven side only
    output logic [RDMA_DATA_W-1:0] dma_data_out,
    output logic dma_data_oe
);

    // ==========================================================
    // Declarations
    rdma_state_t st_q;
    rdma_state_t st_d;

    logic soft_rst;
    logic enabled;
    logic rd_type;
    logic [2:0] chan_code;
    logic chan_valid;
    logic [1:0] chan_idx;

    logic sel_valid;
    rdma_word_t sel_word;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RDMA_WORD_W-1:0] fifo_out_raw;
    rdma_word_t fifo_out;
    logic push;
    logic pop;
    logic push_last;
    logic pop_last;

    logic ack_low;
    logic strobe_low;
    logic strobe_fall;

    logic apb_setup;
    logic apb_access;
    logic hit_cfg;
    logic hit_status;
    logic [31:0] status_word;

    // ==========================================================
    // Configuration fields
    assign soft_rst = st_q.cfg[RDMA_CFG_RST_BIT] && !st_q.rst_prev;
    assign enabled = st_q.cfg[RDMA_CFG_ENB_BIT];
    assign rd_type = st_q.cfg[RDMA_CFG_RDTYPE_BIT];
    assign chan_code = st_q.cfg[RDMA_CFG_CHAN_MSB:RDMA_CFG_CHAN_LSB];

    // Codes 1xx give no channel; 010 is channel 2
    assign chan_valid = !chan_code[2];
    assign chan_idx = chan_code[1:0];

    // ==========================================================
    // Channel selection into the FIFO
    always_comb begin
        sel_valid = 1'b0;
        sel_word = '0;
        ch_ready = '0;
        if (enabled && chan_valid && !soft_rst) begin
            sel_valid = ch_valid[chan_idx];
            sel_word = ch_word[chan_idx];
            ch_ready[chan_idx] = fifo_in_ready;
        end
    end

    assign push = sel_valid && fifo_in_ready;
    assign push_last = push && sel_word.last;
    assign fifo_out = rdma_word_t'(fifo_out_raw);

    // Buffer between line channel and the bus; a stalled DMA fills it
    // and then holds off the channel through ch_ready
    rdma_fifo #(
        .WIDTH(RDMA_WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .reset(reset),
        .flush(soft_rst),
        .in_valid(sel_valid),
        .in_ready(fifo_in_ready),
        .in_data(sel_word),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_raw)
    );

    // ==========================================================
    // Pin view after two synchronising stages; sync3 is only the edge history
    assign ack_low = !st_q.sync2[RDMA_PIN_ACK];
    // Read-type picks which pin strobes the data
    assign strobe_low = rd_type ? !st_q.sync2[RDMA_PIN_WR] : !st_q.sync2[RDMA_PIN_RD];
    assign strobe_fall = rd_type ? (st_q.sync3[RDMA_PIN_WR] && !st_q.sync2[RDMA_PIN_WR])
                                 : (st_q.sync3[RDMA_PIN_RD] && !st_q.sync2[RDMA_PIN_RD]);

    // A word leaves only on a strobe edge inside an acknowledged request
    assign pop = st_q.req && ack_low && strobe_fall && fifo_out_valid && enabled && !soft_rst;
    assign pop_last = pop && fifo_out.last;

    // ==========================================================
    // APB decode
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    always_comb begin
        hit_cfg = 1'b0;
        hit_status = 1'b0;
        if (paddr == RDMA_CFG_OFFSET) begin
            hit_cfg = 1'b1;
        end else if (paddr == RDMA_STATUS_OFFSET) begin
            hit_status = 1'b1;
        end
    end

    // Status shows the channel's own state
    always_comb begin
        status_word = '0;
        status_word[RDMA_STAT_MSGS_LSB +: RDMA_MSGS_W] = st_q.msgs;
        status_word[RDMA_STAT_REQ_BIT] = st_q.req;
        status_word[RDMA_STAT_VALID_BIT] = fifo_out_valid;
        status_word[RDMA_STAT_UNASSIGNED_BIT] = !chan_valid;
    end

    // Zero wait states; data is latched in the setup cycle
    assign pready = 1'b1;
    assign pslverr = apb_access && !hit_cfg && !hit_status;
    assign prdata = st_q.prdata;

    // ==========================================================
    // Next state
    always_comb begin
        st_d = st_q;
        st_d.rst_prev = st_q.cfg[RDMA_CFG_RST_BIT];
        // Two stages before anything reads a pin
        st_d.sync1 = {rx_transfer_acknowledge_n, wr_n, rd_n};
        st_d.sync2 = st_q.sync1;
        st_d.sync3 = st_q.sync2;

        // Register write; reserved bits stay zero
        if (apb_access && pwrite && hit_cfg) begin
            st_d.cfg = pwdata[7:0] & RDMA_CFG_WR_MASK;
        end

        // Read data captured while the address is stable
        if (apb_setup && !pwrite) begin
            if (hit_cfg) begin
                st_d.prdata = {24'h000000, st_q.cfg};
            end else if (hit_status) begin
                st_d.prdata = status_word;
            end else begin
                st_d.prdata = 32'h00000000;
            end
        end

        // Complete messages held in the FIFO
        case ({push_last, pop_last})
            2'b10: st_d.msgs = st_q.msgs + 1'b1;
            2'b01: st_d.msgs = st_q.msgs - 1'b1;
            default: st_d.msgs = st_q.msgs;
        endcase

        // Request rises for a whole message and falls after its last word
        if (!enabled) begin
            st_d.req = 1'b0;
        end else if (!st_q.req && st_q.msgs != '0) begin
            st_d.req = 1'b1;
        end else if (pop_last) begin
            st_d.req = 1'b0;
        end

        // New word on each strobe edge
        if (pop) begin
            st_d.data = fifo_out.data;
        end
        st_d.oe = st_q.req && ack_low && strobe_low && enabled;

        // Soft reset clears the transfer but keeps the configuration
        if (soft_rst) begin
            st_d.msgs = '0;
            st_d.req = 1'b0;
            st_d.oe = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_q <= '0;
            st_q.cfg <= RDMA_CFG_RESET;
            st_q.sync1 <= 3'h7;
            st_q.sync2 <= 3'h7;
            st_q.sync3 <= 3'h7;
        end else begin
            st_q <= st_d;
        end
    end

    // ==========================================================
    // Pin outputs, all from flip-flops
    assign rx_transfer_request_n = !st_q.req;
    assign dma_data_out = st_q.data;
    assign dma_data_oe = st_q.oe;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Soft reset edge on the configuration bit
    sequence s_soft_edge;
        $rose(st_q.cfg[RDMA_CFG_RST_BIT]);
    endsequence

    // A strobe edge inside an acknowledged request
    sequence s_word_taken;
        st_q.req && ack_low && strobe_fall && fifo_out_valid && enabled && !soft_rst;
    endsequence

    AST_SOFT_RESET: assert property (s_soft_edge |=> !st_q.req && st_q.msgs == '0)
        else $error("soft reset did not clear the request and message count");

    AST_DISABLED_IDLE: assert property (!enabled |-> ch_ready == '0 ##1 rx_transfer_request_n)
        else $error("request or intake active while disabled");

    AST_WHOLE_MSG: assert property ($fell(rx_transfer_request_n) |-> $past(st_q.msgs) != '0)
        else $error("request raised without a complete message");

    AST_REQ_START: assert property (enabled && !soft_rst && !st_q.req && st_q.msgs != '0 |=> !rx_transfer_request_n)
        else $error("request not driven low for a buffered message");

    AST_NO_ACK_NO_POP: assert property (!ack_low |-> !pop)
        else $error("word taken without acknowledge");

    AST_RD_STROBE: assert property (!rd_type ##0 s_word_taken |=> dma_data_out == $past(fifo_out.data))
        else $error("read strobe did not present a new word");

    AST_WR_STROBE: assert property (rd_type ##0 s_word_taken |=> dma_data_out == $past(fifo_out.data))
        else $error("write strobe did not present a new word");

    AST_STROBE_PICK: assert property (pop |-> (rd_type ? $fell(st_q.sync2[RDMA_PIN_WR]) : $fell(st_q.sync2[RDMA_PIN_RD])))
        else $error("word taken on the wrong strobe pin");

    AST_CHAN_ROUTE: assert property (enabled && chan_valid && !soft_rst |-> ch_ready[chan_idx] == fifo_in_ready)
        else $error("selected channel not routed to the buffer");

    AST_RESERVED_CODE: assert property (chan_code[2] |-> ch_ready == '0 && !push)
        else $error("reserved channel code assigned the interface");

    AST_LAST_DROPS_REQ: assert property (pop_last && !soft_rst |=> !st_q.req ##1 (st_q.req == ($past(enabled) && !$past(soft_rst) && $past(st_q.msgs) != '0)))
        else $error("request not released after a message");
endmodule

// ---- verif/rdma_dmac_model.sv ----
// External DMA controller model for the receive DMA read channel.
// Assumes the bench sets read_type to match the config and hold to stall.
`timescale 1ns/100ps
module rdma_dmac_model
    import rdma_pkg::*;
(
    // Clock and control from the bench
    input wire logic core_clk,
    input wire logic read_type,
    input wire logic hold,
    // DMA handshake
    input wire logic rx_transfer_request_n,
    output logic rx_transfer_acknowledge_n,
    // Bus strobes and data
    output logic rd_n,
    output logic wr_n,
    input wire logic [RDMA_DATA_W-1:0] dma_data_out
);
    // ==========================================================
    // Collected bytes
    logic [RDMA_DATA_W-1:0] got[$];

    // Pulled-up pins idle high; strobes held 6 low, at least 6 high, above the 3-cycle minimum
    initial begin
        rx_transfer_acknowledge_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        forever begin
            @(posedge core_clk);
            if (rx_transfer_request_n === 1'b0 && !hold) begin
                rx_transfer_acknowledge_n <= 1'b0;
                while (rx_transfer_request_n === 1'b0) begin
                    repeat (2) @(posedge core_clk);
                    if (read_type) begin
                        wr_n <= 1'b0;
                    end else begin
                        rd_n <= 1'b0;
                    end
                    repeat (6) @(posedge core_clk);
                    got.push_back(dma_data_out);
                    rd_n <= 1'b1;
                    wr_n <= 1'b1;
                    repeat (4) @(posedge core_clk);
                end
                rx_transfer_acknowledge_n <= 1'b1;
            end
        end
    end
endmodule

// ---- verif/rdma_core_tb.sv ----
// Self-checking bench for the receive DMA read channel core.
// Assumes zero-wait APB and the controller model in rdma_dmac_model.
`timescale 1ns/100ps
module rdma_core_tb;
    import rdma_pkg::*;
    // ==========================================================
    // Signals
    logic core_clk = 1'b0, reset = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic slverr;
    logic pready, pslverr, req_n, ack_n, rd_n, wr_n, oe, rtype = 1'b0, hold = 1'b0;
    rdma_word_t [3:0] ch_word = '0;
    logic [3:0] ch_valid = 4'h0, ch_ready;
    logic [7:0] dout;
    int fails = 0, n_compared = 0;

    always #20 core_clk = ~core_clk;

    rdma_core #(.FIFO_DEPTH(4), .NUM_CHANNELS(4)) dut (.core_clk(core_clk), .reset(reset), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch_word(ch_word), .ch_valid(ch_valid), .ch_ready(ch_ready),
        .rx_transfer_request_n(req_n), .rx_transfer_acknowledge_n(ack_n), .rd_n(rd_n), .wr_n(wr_n),
        .dma_data_out(dout), .dma_data_oe(oe));
    rdma_dmac_model dmac (.core_clk(core_clk), .read_type(rtype), .hold(hold), .rx_transfer_request_n(req_n),
        .rx_transfer_acknowledge_n(ack_n), .rd_n(rd_n), .wr_n(wr_n), .dma_data_out(dout));

    // ==========================================================
    // Shared tasks
    task complete_run;
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Hold the request until pready is seen at an access edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            fails++;
            complete_run();
        end
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let an edge pass so a following call never re-drives psel in this step
        @(posedge core_clk);
    endtask

    // Bounded wait for a level on the request pin
    task wreq(input logic lvl);
        int k;
        for (k = 0; k < 40 && req_n !== lvl; k++) @(posedge core_clk);
        if (k >= 40) begin
            fails++;
            complete_run();
        end
    endtask

    // Push n words on one channel, last flag on the final one if fin
    task push(input int ch, input int n, input bit fin);
        int i, k;
        logic took;
        for (i = 0; i < n; i++) begin
            ch_word[ch] <= {fin && i == n - 1, 8'(ch * 16 + i)};
            ch_valid[ch] <= 1'b1;
            k = 0;
            // Ready is judged as it stands before the edge that takes the word
            do begin
                @(negedge core_clk);
                took = ch_ready[ch];
                @(posedge core_clk);
                k++;
            end while (took !== 1'b1 && k < 50);
            if (k >= 50) begin
                fails++;
                complete_run();
            end
        end
        ch_valid[ch] <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task s_reset;
        apb(1'b0, RDMA_CFG_OFFSET, 32'h0);
        chk(rd, 32'(RDMA_CFG_RESET));
        chk(32'(req_n), 32'h1);
        apb(1'b0, 12'h0F0, 32'h0);
        chk(32'(slverr), 32'h1);
        $display("test reset done");
    endtask

    // Channel codes 0 to 3, both strobe roles, FIFO filled to refusal then drained
    task s_sweep;
        int c, i, k;
        for (c = 0; c < 4; c++) begin
            hold = 1'b1;
            rtype = c[0];
            dmac.got.delete();
            apb(1'b1, RDMA_CFG_OFFSET, 32'h40 | (32'(c[0]) << 5) | 32'(c));
            push(c, 4, 1'b1);
            @(posedge core_clk);
            chk(32'(ch_ready), 32'h0);
            wreq(1'b0);
            hold = 1'b0;
            for (k = 0; k < 300 && dmac.got.size() < 4; k++) @(posedge core_clk);
            chk(32'(dmac.got.size()), 32'h4);
            for (i = 0; i < 4 && i < dmac.got.size(); i++) chk(32'(dmac.got[i]), 32'(c * 16 + i));
            wreq(1'b1);
        end
        $display("test sweep done");
    endtask

    task s_partial;
        hold = 1'b1;
        rtype = 1'b0;
        apb(1'b1, RDMA_CFG_OFFSET, 32'h41);
        push(1, 2, 1'b0);
        repeat (20) @(posedge core_clk);
        chk(32'(req_n), 32'h1);
        push(1, 1, 1'b1);
        wreq(1'b0);
        $display("test partial done");
    endtask

    // Soft reset flushes the held message
    task s_softreset;
        apb(1'b1, RDMA_CFG_OFFSET, 32'hC1);
        repeat (3) @(posedge core_clk);
        chk(32'(req_n), 32'h1);
        apb(1'b0, RDMA_STATUS_OFFSET, 32'h0);
        chk(rd, 32'h0);
        hold = 1'b0;
        $display("test soft reset done");
    endtask

    task s_refuse;
        apb(1'b1, RDMA_CFG_OFFSET, 32'h00);
        ch_valid <= 4'hF;
        @(posedge core_clk);
        chk(32'(ch_ready), 32'h0);
        apb(1'b1, RDMA_CFG_OFFSET, 32'h46);
        chk(32'(ch_ready), 32'h0);
        apb(1'b0, RDMA_STATUS_OFFSET, 32'h0);
        chk(32'(rd[RDMA_STAT_UNASSIGNED_BIT]), 32'h1);
        ch_valid <= 4'h0;
        $display("test refuse done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        s_reset();
        s_sweep();
        s_partial();
        s_softreset();
        s_refuse();
        complete_run();
    end
endmodule
